// ---- bench/csi_status_bank_monitor.sv ----
// Port-level assertions for the controller status bank
`timescale 1ns/100ps
`default_nettype none
module csi_status_bank_monitor
(
    input wire logic                  ref_clk,
    input wire logic                  resetn,
    input wire logic                  host_wr,
    input wire logic                  host_data_sel,
    input wire logic [15:0]           host_wdata,
    input wire csi_pkg::csi_evt_t     evt,
    input wire csi_pkg::csi_cmd_t     cmd,
    input wire csi_pkg::csi_ext_src_t ext_src,
    input wire csi_pkg::csi_ext_src_t ext_mask,
    input wire logic [4:0]            done_masks,
    input wire logic                  rx_disable,
    input wire logic                  tx_disable,
    input wire logic                  tp_mode,
    input wire logic                  link_fail,
    input wire logic                  desc_fetch,
    input wire csi_pkg::csi_state_t   run_state,
    input wire logic                  fault_summary,
    input wire logic                  irq_req
);
    logic [6:0] idx_q;
    logic       en_q;
    // Shadow of index and enable, so irq can be judged from ports only
    wire        st_wr = host_wr && host_data_sel && idx_q == 7'h00;
    wire        cause = (evt.rx_done && !done_masks[2]) || (evt.tx_done && !done_masks[1])
                        || (evt.setup_done && !done_masks[0])
                        || (evt.lost_frame && !done_masks[4])
                        || (ext_src.tx_overlength_flag && !ext_mask.tx_overlength_flag);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            idx_q <= 7'h00;
            en_q  <= 1'b0;
        end
        else
        begin
            if (host_wr && !host_data_sel)
                idx_q <= host_wdata[6:0];
            if (cmd.stop)
                en_q <= 1'b0;
            else if (st_wr)
                en_q <= host_wdata[6];
        end
    end
    property p_irq_en;
        irq_req |-> en_q;
    endproperty
    a_irq_en: assert property (p_irq_en) else $error("irq without enable");
    property p_irq_set;
        cause && en_q && !cmd.stop && !host_wr |=> irq_req;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("irq missing");
    property p_fault_set;
        (evt.lost_frame || (evt.tx_attempt && tp_mode && link_fail)) && !cmd.stop |=> fault_summary;
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("fault missing");
    property p_fault_stop;
        cmd.stop && !ext_src.tx_overlength_flag |=> !fault_summary;
    endproperty
    a_fault_stop: assert property (p_fault_stop) else $error("fault kept");
    property p_stop_clear;
        cmd.stop |=> run_state == 3'h0;
    endproperty
    a_stop_clear: assert property (p_stop_clear) else $error("state kept");
    property p_rx_on;
        cmd.run_command && !cmd.init && !cmd.stop && !rx_disable |=> run_state.rx_active;
    endproperty
    a_rx_on: assert property (p_rx_on) else $error("rx not active");
    property p_tx_on;
        cmd.run_command && !cmd.init && !cmd.stop && !tx_disable |=> run_state.tx_active;
    endproperty
    a_tx_on: assert property (p_tx_on) else $error("tx not active");
    property p_init_wait;
        cmd.run_command && cmd.init && !cmd.stop && !run_state.rx_active && !evt.setup_done
            ##1 !evt.setup_done && !cmd.run_command |-> !run_state.rx_active [*2];
    endproperty
    a_init_wait: assert property (p_init_wait) else $error("rx active early");
    property p_poll_fetch;
        desc_fetch && !host_wr |=> !run_state.tx_poll_now;
    endproperty
    a_poll_fetch: assert property (p_poll_fetch) else $error("poll kept");
    property p_poll_idle;
        !run_state.tx_active && !cmd.run_command && !evt.setup_done |=> !run_state.tx_poll_now;
    endproperty
    a_poll_idle: assert property (p_poll_idle) else $error("poll while idle");
endmodule
`default_nettype wire

// ---- bench/csi_status_bank_tb.sv ----
// Self-checking bench for the controller status bank
`timescale 1ns/100ps
`default_nettype none
module csi_status_bank_tb;
    logic                  ref_clk;
    logic                  resetn;
    logic                  host_wr;
    logic                  host_rd;
    logic                  host_data_sel;
    logic [15:0]           host_wdata;
    logic [15:0]           host_rdata;
    csi_pkg::csi_evt_t     evt;
    csi_pkg::csi_cmd_t     cmd;
    csi_pkg::csi_ext_src_t ext_src;
    csi_pkg::csi_ext_src_t ext_mask;
    logic [4:0]            done_masks;
    logic                  rx_disable;
    logic                  tx_disable;
    logic                  tp_mode;
    logic                  link_fail;
    logic                  bus_master;
    logic                  dma_req;
    logic                  desc_fetch;
    logic                  aui_collision;
    logic                  dma_ack;
    csi_pkg::csi_state_t   run_state;
    logic                  fault_summary;
    logic                  irq_req;
    int                    fails;
    int                    checks_done;
    // Event, status bit and mask per sticky source: rx, tx, setup, lost
    localparam logic [5:0]  et_tab [4] = '{6'h10, 6'h08, 6'h04, 6'h20};
    localparam logic [15:0] st_tab [4] = '{16'h0400, 16'h0200, 16'h0100, 16'h9000};
    localparam logic [4:0]  dm_tab [4] = '{5'h04, 5'h02, 5'h01, 5'h10};
    csi_status_bank uut
    (
        .ref_clk(ref_clk), .resetn(resetn), .host_wr(host_wr), .host_rd(host_rd),
        .host_data_sel(host_data_sel), .host_wdata(host_wdata), .host_rdata(host_rdata),
        .evt(evt), .cmd(cmd), .run_bits(3'h5), .ext_src(ext_src), .ext_mask(ext_mask),
        .done_masks(done_masks), .rx_disable(rx_disable), .tx_disable(tx_disable),
        .tp_mode(tp_mode), .link_fail(link_fail), .bus_master(bus_master),
        .dma_req(dma_req), .desc_fetch(desc_fetch), .aui_collision(aui_collision),
        .dma_ack(dma_ack), .run_state(run_state), .fault_summary(fault_summary),
        .irq_req(irq_req)
    );
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask
    task automatic wr(input logic sel, input logic [15:0] d);
        @(posedge ref_clk);
        host_wr       <= 1'b1;
        host_data_sel <= sel;
        host_wdata    <= d;
        @(posedge ref_clk);
        host_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic sel, input logic [15:0] exp);
        @(posedge ref_clk);
        host_rd       <= 1'b1;
        host_data_sel <= sel;
        @(posedge ref_clk);
        host_rd <= 1'b0;
        #1;
        chk(host_rdata, exp);
    endtask
    task automatic ev(input logic [5:0] e);
        @(posedge ref_clk) evt <= e;
        @(posedge ref_clk) evt <= 6'h00;
        #1;
    endtask
    task automatic cm(input logic [2:0] c);
        @(posedge ref_clk) cmd <= c;
        @(posedge ref_clk) cmd <= 3'h0;
        #1;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // Hang guard
    initial
    begin
        repeat (30000) @(posedge ref_clk);
        fails++;
        finish_test();
    end
    initial
    begin
        fails = 0;
        checks_done = 0;
        resetn = 1'b0;
        {host_wr, host_rd, host_data_sel, host_wdata} = '0;
        {evt, cmd, ext_src, ext_mask, done_masks} = '0;
        {rx_disable, tx_disable, tp_mode, link_fail, bus_master} = '0;
        {dma_req, desc_fetch, aui_collision, dma_ack} = '0;
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        rd(1'b1, 16'h0005);
        wr(1'b0, 16'h0001);
        rd(1'b0, 16'h0001);
        rd(1'b1, 16'h0000);
        wr(1'b0, 16'h0000);
        wr(1'b1, 16'h0040);
        rd(1'b1, 16'h0045);
        for (int i = 0; i < 4; i++)
        begin
            ev(et_tab[i]);
            chk({15'h0000, irq_req}, 16'h0001);
            rd(1'b1, st_tab[i] | 16'h00C5);
            wr(1'b1, (st_tab[i] & 16'h7FFF) | 16'h0040);
            rd(1'b1, 16'h0045);
            @(posedge ref_clk) done_masks <= dm_tab[i];
            ev(et_tab[i]);
            chk({15'h0000, irq_req}, 16'h0000);
            rd(1'b1, st_tab[i] | 16'h0045);
            wr(1'b1, (st_tab[i] & 16'h7FFF) | 16'h0040);
            @(posedge ref_clk) done_masks <= 5'h00;
        end
        ev(6'h10);
        wr(1'b1, 16'h0040);
        rd(1'b1, 16'h04C5);
        // Event racing its own clear must survive
        @(posedge ref_clk);
        evt        <= 6'h10;
        host_wr    <= 1'b1;
        host_wdata <= 16'h0440;
        @(posedge ref_clk);
        evt     <= 6'h00;
        host_wr <= 1'b0;
        rd(1'b1, 16'h04C5);
        wr(1'b1, 16'h0000);
        chk({15'h0000, irq_req}, 16'h0000);
        rd(1'b1, 16'h0485);
        wr(1'b1, 16'h0440);
        rd(1'b1, 16'h0045);
        ev(6'h02);
        tick(30);
        rd(1'b1, 16'hA045);
        chk({15'h0000, irq_req}, 16'h0000);
        wr(1'b1, 16'h2040);
        ev(6'h02);
        tick(5);
        @(posedge ref_clk) aui_collision <= 1'b1;
        tick(5);
        @(posedge ref_clk) aui_collision <= 1'b0;
        tick(25);
        rd(1'b1, 16'h0045);
        @(posedge ref_clk) {tp_mode, link_fail} <= 2'b11;
        ev(6'h01);
        rd(1'b1, 16'hA045);
        wr(1'b1, 16'h2040);
        @(posedge ref_clk) {tp_mode, link_fail} <= 2'b00;
        @(posedge ref_clk) bus_master <= 1'b1;
        @(posedge ref_clk) dma_req <= 1'b1;
        tick(450);
        rd(1'b1, 16'h0045);
        tick(60);
        rd(1'b1, 16'h88C5);
        wr(1'b1, 16'h0840);
        @(posedge ref_clk) dma_req <= 1'b0;
        @(posedge ref_clk) dma_req <= 1'b1;
        tick(100);
        @(posedge ref_clk) dma_ack <= 1'b1;
        tick(5);
        @(posedge ref_clk) {dma_req, dma_ack} <= 2'b00;
        tick(500);
        rd(1'b1, 16'h0045);
        @(posedge ref_clk) rx_disable <= 1'b1;
        cm(3'h2);
        rd(1'b1, 16'h0055);
        wr(1'b1, 16'h0048);
        rd(1'b1, 16'h005D);
        @(posedge ref_clk) desc_fetch <= 1'b1;
        @(posedge ref_clk) desc_fetch <= 1'b0;
        rd(1'b1, 16'h0055);
        cm(3'h4);
        rd(1'b1, 16'h0005);
        @(posedge ref_clk) rx_disable <= 1'b0;
        wr(1'b1, 16'h0008);
        rd(1'b1, 16'h0005);
        cm(3'h3);
        rd(1'b1, 16'h0005);
        ev(6'h04);
        rd(1'b1, 16'h01B5);
        chk({15'h0000, irq_req}, 16'h0000);
        wr(1'b1, 16'h0008);
        cm(3'h4);
        rd(1'b1, 16'h0005);
        wr(1'b1, 16'h0040);
        @(posedge ref_clk) ext_src <= 5'h10;
        tick(2);
        rd(1'b1, 16'hC0C5);
        @(posedge ref_clk) ext_mask <= 5'h10;
        tick(2);
        rd(1'b1, 16'hC045);
        @(posedge ref_clk) ext_src <= 5'h0F;
        tick(2);
        rd(1'b1, 16'h00C5);
        chk({15'h0000, irq_req}, 16'h0001);
        cm(3'h2);
        rd(1'b1, 16'h00F5);
        finish_test();
    end
endmodule
bind csi_status_bank csi_status_bank_monitor mon
(
    .ref_clk(ref_clk), .resetn(resetn), .host_wr(host_wr), .host_data_sel(host_data_sel),
    .host_wdata(host_wdata), .evt(evt), .cmd(cmd), .ext_src(ext_src), .ext_mask(ext_mask),
    .done_masks(done_masks), .rx_disable(rx_disable), .tx_disable(tx_disable),
    .tp_mode(tp_mode), .link_fail(link_fail), .desc_fetch(desc_fetch),
    .run_state(run_state), .fault_summary(fault_summary), .irq_req(irq_req)
);
`default_nettype wire

// ---- verilog/csi_pkg.sv ----
// Constants and carrier types for the controller status bank
`default_nettype none
package csi_pkg;
    // Indexed register port
    localparam int unsigned RAP_W            = 7;
    localparam logic [6:0]  CSR_STATUS_IDX   = 7'h00;
    localparam logic [15:0] STATUS_RESET     = 16'h0000;
    localparam logic [6:0]  RAP_RESET        = 7'h00;

    // Field positions inside controller_status
    localparam int unsigned POS_FAULT        = 15;
    localparam int unsigned POS_OVERLENGTH   = 14;
    localparam int unsigned POS_STICKY_LO    = 8;
    localparam int unsigned STICKY_N         = 6;
    localparam int unsigned POS_IRQ_SUMMARY  = 7;
    localparam int unsigned POS_IRQ_ENABLE   = 6;
    localparam int unsigned POS_RX_ACTIVE    = 5;
    localparam int unsigned POS_TX_ACTIVE    = 4;
    localparam int unsigned POS_POLL_NOW     = 3;

    // Sticky flag index (bit = POS_STICKY_LO + index)
    localparam int unsigned SF_SETUP         = 0;
    localparam int unsigned SF_TX_DONE       = 1;
    localparam int unsigned SF_RX_DONE       = 2;
    localparam int unsigned SF_BUS_TIMEOUT   = 3;
    localparam int unsigned SF_LOST_FRAME    = 4;
    localparam int unsigned SF_SQE_FAIL      = 5;

    // Timing
    localparam int unsigned CLK_PERIOD_NS    = 100;
    localparam int unsigned BIT_TIME_NS      = 100;
    localparam int unsigned SQE_WINDOW_BITS  = 20;
    localparam int unsigned SQE_WINDOW_CYC   =
        (SQE_WINDOW_BITS * BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned BUS_GRANT_US     = 50;
    localparam int unsigned BUS_GRANT_CYC    =
        (BUS_GRANT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Hardware events, one-cycle pulses from same-clock logic
    typedef struct packed {
        logic lost_frame;
        logic rx_done;
        logic tx_done;
        logic setup_done;
        logic tx_end;
        logic tx_attempt;
    } csi_evt_t;

    // Interrupt sources held outside this bank (levels)
    typedef struct packed {
        logic tx_overlength_flag;
        logic missed_count_wrap;
        logic collision_count_wrap;
        logic jabber_flag;
        logic tx_start_flag;
    } csi_ext_src_t;

    // Run commands, one-cycle pulses
    typedef struct packed {
        logic stop;
        logic run_command;
        logic init;
    } csi_cmd_t;

    // Status toward buffer management
    typedef struct packed {
        logic rx_active;
        logic tx_active;
        logic tx_poll_now;
    } csi_state_t;
endpackage
`default_nettype wire

// ---- verilog/csi_status_bank.sv ----
// Controller status register low part: sticky flags, interrupt summary, run state
//
// Functional notes
// - SQE fail if no collision within 20 bits
// - Twisted-pair transmit during link fail sets SQE fail
// - SQE fail never requests an interrupt
// - SQE, lost, timeout flags raise fault summary
// - Sticky flags clear on write one, reset, stop
// - Dropped frame without descriptor sets lost flag
// - Bus master waits 50 us for acknowledge
// - Lost frame, timeout interrupt when enabled, unmasked
// - Receive done after frame and ownership return
// - Transmit done after frame and ownership return
// - Setup complete after initialization block read
// - Done flags interrupt when enabled and unmasked
// - Summary is OR of unmasked sources
// - Summary read-only, self-clearing, reset and stop clear
// - Interrupt output needs summary and global enable
// - Global enable read/write, reset and stop clear
// - Receive active after start, or after setup when init rides along
// - Transmit active likewise; reset, stop clear both
// - Poll now fetches ring; self-clears when idle
// - Descriptor fetch, reset, stop clear poll now
// - Fault summary ORs four error flags
`default_nettype none
`timescale 1ns/100ps
module csi_status_bank
(
    input  wire logic                  ref_clk,
    input  wire logic                  resetn,
    // Indexed register port
    input  wire logic                  host_wr,
    input  wire logic                  host_rd,
    input  wire logic                  host_data_sel,
    input  wire logic [15:0]           host_wdata,
    output logic      [15:0]           host_rdata,
    // Surrounding controller
    input  wire csi_pkg::csi_evt_t     evt,
    input  wire csi_pkg::csi_cmd_t     cmd,
    input  wire logic [2:0]            run_bits,
    input  wire csi_pkg::csi_ext_src_t ext_src,
    input  wire csi_pkg::csi_ext_src_t ext_mask,
    input  wire logic [4:0]            done_masks,
    input  wire logic                  rx_disable,
    input  wire logic                  tx_disable,
    input  wire logic                  tp_mode,
    input  wire logic                  link_fail,
    input  wire logic                  bus_master,
    input  wire logic                  dma_req,
    input  wire logic                  desc_fetch,
    // Pins
    input  wire logic                  aui_collision,
    input  wire logic                  dma_ack,
    // Results
    output csi_pkg::csi_state_t        run_state,
    output logic                       fault_summary,
    output logic                       irq_req
);
    // Data-port write that carries a one in the given bit of the status word
    function automatic logic w1(input logic wr, input logic [15:0] d, input int unsigned pos);
        w1 = wr && d[pos];
    endfunction

    logic [csi_pkg::RAP_W-1:0]    rap_q;
    logic [csi_pkg::STICKY_N-1:0] sticky_q;
    logic [csi_pkg::STICKY_N-1:0] sticky_d;
    logic [csi_pkg::STICKY_N-1:0] sticky_set;
    logic                         summary_q;
    logic                         enable_q;
    logic                         rx_active_q;
    logic                         tx_active_q;
    logic                         rx_pend_q;
    logic                         tx_pend_q;
    logic                         poll_q;
    logic                         fault_q;
    logic                         irq_q;
    logic [15:0]                  rdata_q;
    logic                         dma_req_q;

    logic                         coll_sync;
    logic                         ack_sync;
    logic                         sqe_expire;
    logic                         grant_expire;
    logic                         dma_start;
    logic                         dma_abort;

    logic                         wr_rap;
    logic                         wr_status;
    logic                         stop_clr;
    logic                         start_now;
    logic                         start_with_init;
    logic                         summary_d;
    logic                         fault_d;
    logic                         enable_d;
    logic                         rx_active_d;
    logic                         tx_active_d;
    logic                         poll_d;
    logic                         ext_pending;
    logic                         own_pending;
    logic [15:0]                  status_word;
    logic [15:0]                  read_word;

    // Pin inputs cross into ref_clk
    csi_sync2 u_sync_coll
    (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .async_in (aui_collision),
        .sync_out (coll_sync)
    );

    csi_sync2 u_sync_ack
    (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .async_in (dma_ack),
        .sync_out (ack_sync)
    );

    // Heartbeat window after each transmission
    csi_window_timer #(.CYCLES(csi_pkg::SQE_WINDOW_CYC)) u_sqe_win
    (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .start   (evt.tx_end),
        .hit     (coll_sync),
        .abort   (stop_clr),
        .expire  (sqe_expire)
    );

    // Grant watchdog: restarts on each new request while mastering
    assign dma_start = bus_master && dma_req && !dma_req_q;
    assign dma_abort = stop_clr || !dma_req || !bus_master;

    csi_window_timer #(.CYCLES(csi_pkg::BUS_GRANT_CYC)) u_grant_win
    (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .start   (dma_start),
        .hit     (ack_sync),
        .abort   (dma_abort),
        .expire  (grant_expire)
    );

    // Port decode
    assign wr_rap    = host_wr && !host_data_sel;
    assign wr_status = host_wr && host_data_sel && (rap_q == csi_pkg::CSR_STATUS_IDX);
    assign stop_clr  = cmd.stop;

    // Stop overrides start and init given together
    assign start_now       = cmd.run_command && !cmd.init && !cmd.stop;
    assign start_with_init = cmd.run_command && cmd.init && !cmd.stop;

    // Event sources for sticky flags
    assign sticky_set[csi_pkg::SF_SQE_FAIL]    = sqe_expire
                                               || (tp_mode && link_fail && evt.tx_attempt);
    assign sticky_set[csi_pkg::SF_LOST_FRAME]  = evt.lost_frame;
    assign sticky_set[csi_pkg::SF_BUS_TIMEOUT] = grant_expire;
    assign sticky_set[csi_pkg::SF_RX_DONE]     = evt.rx_done;
    assign sticky_set[csi_pkg::SF_TX_DONE]     = evt.tx_done;
    assign sticky_set[csi_pkg::SF_SETUP]       = evt.setup_done;

    // Set beats a same-cycle write-one clear; stop beats everything
    genvar gi;
    generate
        for (gi = 0; gi < csi_pkg::STICKY_N; gi++)
        begin : g_sticky
            assign sticky_d[gi] = !stop_clr
                && (sticky_set[gi]
                    || (sticky_q[gi]
                        && !w1(wr_status, host_wdata, csi_pkg::POS_STICKY_LO + gi)));
        end
    endgenerate

    // Of the sticky flags only lost frame down to setup complete can interrupt; SQE fail is left out
    assign own_pending = |(sticky_d[csi_pkg::SF_LOST_FRAME:csi_pkg::SF_SETUP]
                           & ~done_masks);
    assign ext_pending = |(ext_src & ~ext_mask);
    assign summary_d   = !stop_clr && (own_pending || ext_pending);

    assign fault_d = ext_src.tx_overlength_flag
                   || sticky_d[csi_pkg::SF_SQE_FAIL]
                   || sticky_d[csi_pkg::SF_LOST_FRAME]
                   || sticky_d[csi_pkg::SF_BUS_TIMEOUT];

    // Global enable is a plain read/write bit
    assign enable_d = stop_clr ? 1'b0
                    : wr_status ? host_wdata[csi_pkg::POS_IRQ_ENABLE]
                    : enable_q;

    // Active bits come up on start, or after setup when init rides along
    assign rx_active_d = !stop_clr
        && (rx_active_q
            || (start_now && !rx_disable)
            || (rx_pend_q && evt.setup_done));
    assign tx_active_d = !stop_clr
        && (tx_active_q
            || (start_now && !tx_disable)
            || (tx_pend_q && evt.setup_done));

    // Poll request needs transmit running; a fresh write beats a fetch
    assign poll_d = !stop_clr && tx_active_q
        && (w1(wr_status, host_wdata, csi_pkg::POS_POLL_NOW)
            || (poll_q && !desc_fetch));

    assign status_word = {fault_q,
                          ext_src.tx_overlength_flag,
                          sticky_q[csi_pkg::SF_SQE_FAIL],
                          sticky_q[csi_pkg::SF_LOST_FRAME],
                          sticky_q[csi_pkg::SF_BUS_TIMEOUT],
                          sticky_q[csi_pkg::SF_RX_DONE],
                          sticky_q[csi_pkg::SF_TX_DONE],
                          sticky_q[csi_pkg::SF_SETUP],
                          summary_q,
                          enable_q,
                          rx_active_q,
                          tx_active_q,
                          poll_q,
                          run_bits};

    // Other indexes belong elsewhere and read as zero here
    assign read_word = !host_data_sel ? {9'h000, rap_q}
                     : (rap_q == csi_pkg::CSR_STATUS_IDX) ? status_word
                     : 16'h0000;

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            rap_q <= csi_pkg::RAP_RESET;
        else if (wr_rap)
            rap_q <= host_wdata[csi_pkg::RAP_W-1:0];
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            sticky_q <= '0;
        else
            sticky_q <= sticky_d;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            summary_q <= 1'b0;
        else
            summary_q <= summary_d;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            fault_q <= 1'b0;
        else
            fault_q <= fault_d;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            enable_q <= 1'b0;
        else
            enable_q <= enable_d;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            rx_active_q <= 1'b0;
        else
            rx_active_q <= rx_active_d;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            tx_active_q <= 1'b0;
        else
            tx_active_q <= tx_active_d;
    end

    // Pending start waits for the setup-complete pulse
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            rx_pend_q <= 1'b0;
        else
            rx_pend_q <= !stop_clr && !evt.setup_done
                      && (rx_pend_q || (start_with_init && !rx_disable));
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            tx_pend_q <= 1'b0;
        else
            tx_pend_q <= !stop_clr && !evt.setup_done
                      && (tx_pend_q || (start_with_init && !tx_disable));
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            poll_q <= 1'b0;
        else
            poll_q <= poll_d;
    end

    // Outputs straight from flops; request moves with the summary
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            irq_q <= 1'b0;
        else
            irq_q <= summary_d && enable_d;
    end

    // Previous request level, for the rising-edge start
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            dma_req_q <= 1'b0;
        else
            dma_req_q <= dma_req;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            rdata_q <= csi_pkg::STATUS_RESET;
        else if (host_rd)
            rdata_q <= read_word;
    end

    assign host_rdata            = rdata_q;
    assign irq_req               = irq_q;
    assign fault_summary         = fault_q;
    assign run_state.rx_active   = rx_active_q;
    assign run_state.tx_active   = tx_active_q;
    assign run_state.tx_poll_now = poll_q;
endmodule
`default_nettype wire

// ---- verilog/csi_sync2.sv ----
// Two-stage synchroniser for one level arriving from a pin
`default_nettype none
`timescale 1ns/100ps
module csi_sync2
(
    input  wire logic ref_clk,
    input  wire logic resetn,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_q;

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_q   <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ---- verilog/csi_window_timer.sv ----
// Watch window: pulses expire when no hit arrives within CYCLES cycles of start
`default_nettype none
`timescale 1ns/100ps
module csi_window_timer
#(
    parameter int unsigned CYCLES = 20
)
(
    input  wire logic ref_clk,
    input  wire logic resetn,
    input  wire logic start,
    input  wire logic hit,
    input  wire logic abort,
    output logic      expire
);
    localparam int unsigned CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES);
    localparam logic [CW-1:0] ONE  = CW'(1);

    logic [CW-1:0] count_q;
    logic          run_q;
    logic          last;

    assign last = run_q && (count_q == ONE) && !hit && !abort;

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            count_q <= '0;
            run_q   <= 1'b0;
            expire  <= 1'b0;
        end
        else
        begin
            expire <= last;
            if (start)
            begin
                count_q <= LOAD;
                run_q   <= 1'b1;
            end
            else if (hit || abort || last)
                run_q <= 1'b0;
            else if (run_q)
                count_q <= count_q - ONE;
        end
    end
endmodule
`default_nettype wire
